// File: hw/tfh_cfg.svh
// Purpose: Constants shared by both ends of the sensor control link
// Assumes: Included by bare name from the device, host and verification files
// Notes:   Offsets, codes, bit positions, field widths and reset values only
`ifndef TFH_CFG_SVH
`define TFH_CFG_SVH

// ****************************************
// Device register map
// ****************************************
`define TFH_OFF_APP      8'h00
`define TFH_OFF_REV      8'h01
`define TFH_OFF_REQ      8'h02
`define TFH_OFF_PWR      8'hE0
`define TFH_OFF_FLAG     8'hE1
`define TFH_OFF_INTEN    8'hE2
`define TFH_HI_BASE      8'hE0

// ****************************************
// Codes, fields, reset values
// ****************************************
`define TFH_CODE_MEAS    8'hC0
`define TFH_CODE_BOOT    8'h80
`define TFH_BYTE_RST     8'h00
`define TFH_PWR_RST_BIT  7
`define TFH_PWR_UP_BIT   6
`define TFH_PWR_OSC_BIT  0
`define TFH_OSC_RST      1'b1
`define TFH_NFLAG        2
`define TFH_FLAG_RES     0
`define TFH_FLAG_HIST    1
`define TFH_FLAG_RST     2'h0

// ****************************************
// Host controller register map
// ****************************************
`define TFH_H_SWITCH     8'h00
`define TFH_H_STAT       8'h01
`define TFH_H_ADDR       8'h02
`define TFH_H_WDATA      8'h03
`define TFH_H_GO         8'h04
`define TFH_H_RDATA      8'h05
`define TFH_H_IRQ_ST     8'h06
`define TFH_H_IRQ_MASK   8'h07
`define TFH_H_GO_WR      0
`define TFH_H_GO_RD      1
`define TFH_H_NIRQ       3
`define TFH_H_EV_SWITCH  0
`define TFH_H_EV_DEVINT  1
`define TFH_H_EV_ACCESS  2
`define TFH_H_IRQ_RST    3'h0

`endif

// File: hw/tfh_pkg.sv
// Purpose: Types shared by both ends
// Assumes: Nothing beyond the constants header
// Notes:   Host states are Gray coded along the switch path
package tfh_pkg;
	// Link byte
	typedef logic [7:0] tfh_byte_t;

	// Host sequencer states
	typedef enum logic [2:0] {
		TFH_ST_IDLE = 3'h0,
		TFH_ST_REQ  = 3'h1,
		TFH_ST_POLL = 3'h3,
		TFH_ST_CHK  = 3'h2,
		TFH_ST_ACC  = 3'h6
	} tfh_state_t;
endpackage : tfh_pkg

// File: hw/tfh_link_if.sv
// Purpose: Register link between host controller and sensor device
// Assumes: Both ends on the same clock
// Notes:   Read data stands the cycle after the read strobe only
`timescale 1ns/1ps
interface tfh_link_if;
	import tfh_pkg::*;
	tfh_byte_t addr;   // Register offset
	tfh_byte_t wdata;  // Write data
	logic      wr;     // Write strobe
	logic      rd;     // Read strobe
	tfh_byte_t rdata;  // Read data, one cycle later
	logic      int_n;  // Interrupt, active low

	// Host end
	modport host (output addr, output wdata, output wr, output rd,
		input rdata, input int_n);
	// Device end
	modport dev (input addr, input wdata, input wr, input rd,
		output rdata, output int_n);
endinterface : tfh_link_if

// File: hw/tfh_sticky.sv
// Purpose: Sticky event bits cleared by writing one
// Assumes: Clear mask already qualified by write decode
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
module tfh_sticky #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Events and clear mask
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	// Held bits
	output logic      [W-1:0] q_o
);
	genvar g;
	// One flop per event bit
	for (g = 0; g < W; g++) begin : g_bit
		logic bit_q;
		logic bit_d;
		assign bit_d = set_i[g] | (bit_q & ~clr_i[g]);
		// Bit register
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				bit_q <= 1'b0;
			end else begin
				bit_q <= bit_d;
			end
		end
		assign q_o[g] = bit_q;
	end
endmodule : tfh_sticky

// File: hw/tfh_dev.sv
// Purpose: Sensor device end: host visible control and status registers
// Assumes: Firmware side drives the fw_* inputs on the same clock
// Notes:   Low space is closed while the core-up flag is clear
`timescale 1ns/1ps
`include "tfh_cfg.svh"
module tfh_dev
	import tfh_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	// Link
	tfh_link_if.dev        link,
	// Firmware writes to host visible registers, standby done to the oscillator
	input  wire tfh_byte_t fw_app_code_i,
	input  wire logic      fw_app_code_we_i,
	input  wire tfh_byte_t fw_rev_i,
	input  wire logic      fw_rev_we_i,
	input  wire logic      fw_core_up_i,
	input  wire logic      fw_standby_i,
	// Firmware events
	input  wire logic      fw_result_evt_i,
	input  wire logic      fw_hist_evt_i,
	// Core control towards firmware
	output tfh_byte_t      launch_request_o,
	output logic           cpu_reset_o,
	output logic           osc_wake_irq_o,
	output logic           standby_irq_o,
	output logic           osc_run_o,
	output logic           fw_idle_o
);
	// ****************************************
	// State
	// ****************************************
	tfh_byte_t              app_q;       // Running application code
	tfh_byte_t              rev_q;       // Major revision
	tfh_byte_t              req_q;       // Launch request
	logic                   core_up_q;   // Core ready for low space
	logic                   osc_pon_q;   // Oscillator power-on bit
	logic                   osc_run_q;   // Oscillator running
	logic                   rst_q;       // Core reset pulse
	logic                   wake_q;      // Wake interrupt pulse
	logic                   stby_q;      // Standby request pulse
	logic                   idle_q;      // Measure app idling
	logic [`TFH_NFLAG-1:0]  inten_q;     // Interrupt enables
	logic [`TFH_NFLAG-1:0]  flags;       // Interrupt flags
	logic                   int_n_q;     // Interrupt pin
	tfh_byte_t              rdata_q;     // Read data
	tfh_byte_t              rd_mux;      // Read selection

	// ****************************************
	// Address decode
	// ****************************************
	wire lo_space   = link.addr < `TFH_HI_BASE;
	wire lo_open    = core_up_q;
	wire wr_app     = link.wr && link.addr == `TFH_OFF_APP && lo_open;
	wire wr_rev     = link.wr && link.addr == `TFH_OFF_REV && lo_open;
	wire wr_req     = link.wr && link.addr == `TFH_OFF_REQ && lo_open;
	wire wr_pwr     = link.wr && link.addr == `TFH_OFF_PWR;
	wire wr_flag    = link.wr && link.addr == `TFH_OFF_FLAG;
	wire wr_inten   = link.wr && link.addr == `TFH_OFF_INTEN;
	wire wd_rst     = link.wdata[`TFH_PWR_RST_BIT];
	wire wd_osc     = link.wdata[`TFH_PWR_OSC_BIT];
	wire wake_d     = wr_pwr && !osc_pon_q && wd_osc;
	wire stby_d     = wr_pwr && !wd_osc;
	wire app_boot   = app_q == `TFH_CODE_BOOT;
	wire app_meas   = app_q == `TFH_CODE_MEAS;
	wire rst_d      = (wr_pwr && wd_rst) || (wake_q && app_boot);
	wire [`TFH_NFLAG-1:0] flag_set;
	wire [`TFH_NFLAG-1:0] flag_clr;
	assign flag_set[`TFH_FLAG_RES]  = fw_result_evt_i;
	assign flag_set[`TFH_FLAG_HIST] = fw_hist_evt_i;
	assign flag_clr = wr_flag ? link.wdata[`TFH_NFLAG-1:0] : `TFH_FLAG_RST;
	wire irq_any    = |(flags & inten_q);

	// ****************************************
	// Interrupt flags
	// ****************************************
	tfh_sticky #(
		.W(`TFH_NFLAG)
	) u_flags (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.set_i  (flag_set),
		.clr_i  (flag_clr),
		.q_o    (flags)
	);

	// ****************************************
	// Core registers, cleared by core reset
	// ****************************************
	// Application identity and request
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || rst_q) begin
			app_q <= `TFH_BYTE_RST;
			rev_q <= `TFH_BYTE_RST;
			req_q <= `TFH_BYTE_RST;
		end else begin
			if (fw_app_code_we_i) begin
				app_q <= fw_app_code_i;
			end else if (wr_app) begin
				app_q <= link.wdata;
			end
			if (fw_rev_we_i) begin
				rev_q <= fw_rev_i;
			end else if (wr_rev) begin
				rev_q <= link.wdata;
			end
			if (wr_req) begin
				req_q <= link.wdata;
			end
		end
	end

	// Core-up flag
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || rst_q) begin
			core_up_q <= 1'b0;
		end else if (fw_core_up_i) begin
			core_up_q <= 1'b1;
		end
	end

	// Measure app idle after wake
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || rst_q) begin
			idle_q <= 1'b0;
		end else if (wake_q && app_meas) begin
			idle_q <= 1'b1;
		end else if (stby_q) begin
			idle_q <= 1'b0;
		end
	end

	// ****************************************
	// Power and oscillator control
	// ****************************************
	// Power-on bit and pulses
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			osc_pon_q <= `TFH_OSC_RST;
			rst_q     <= 1'b0;
			wake_q    <= 1'b0;
			stby_q    <= 1'b0;
		end else begin
			if (wr_pwr) begin
				osc_pon_q <= wd_osc;
			end
			rst_q  <= rst_d;
			wake_q <= wake_d;
			stby_q <= stby_d;
		end
	end

	// Oscillator run state
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			osc_run_q <= `TFH_OSC_RST;
		end else if (wake_d) begin
			osc_run_q <= 1'b1;
		end else if (fw_standby_i) begin
			osc_run_q <= 1'b0;
		end
	end

	// Interrupt enables
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			inten_q <= `TFH_FLAG_RST;
		end else if (wr_inten) begin
			inten_q <= link.wdata[`TFH_NFLAG-1:0];
		end
	end

	// ****************************************
	// Read path and interrupt pin
	// ****************************************
	// Read selection
	always_comb begin
		rd_mux = `TFH_BYTE_RST;
		if (lo_space && !lo_open) begin
			rd_mux = `TFH_BYTE_RST;
		end else if (link.addr == `TFH_OFF_APP) begin
			rd_mux = app_q;
		end else if (link.addr == `TFH_OFF_REV) begin
			rd_mux = rev_q;
		end else if (link.addr == `TFH_OFF_REQ) begin
			rd_mux = req_q;
		end else if (link.addr == `TFH_OFF_PWR) begin
			rd_mux[`TFH_PWR_RST_BIT] = rst_q;
			rd_mux[`TFH_PWR_UP_BIT]  = core_up_q;
			rd_mux[`TFH_PWR_OSC_BIT] = osc_pon_q;
		end else if (link.addr == `TFH_OFF_FLAG) begin
			rd_mux[`TFH_NFLAG-1:0] = flags;
		end else if (link.addr == `TFH_OFF_INTEN) begin
			rd_mux[`TFH_NFLAG-1:0] = inten_q;
		end
	end

	// Read data and pin flops
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= `TFH_BYTE_RST;
			int_n_q <= 1'b1;
		end else begin
			rdata_q <= link.rd ? rd_mux : `TFH_BYTE_RST;
			int_n_q <= !irq_any;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.rdata       = rdata_q;
	assign link.int_n       = int_n_q;
	assign launch_request_o = req_q;
	assign cpu_reset_o      = rst_q;
	assign osc_wake_irq_o   = wake_q;
	assign standby_irq_o    = stby_q;
	assign osc_run_o        = osc_run_q;
	assign fw_idle_o        = idle_q;
endmodule : tfh_dev

// File: hw/tfh_host.sv
// Purpose: Host controller end: app switch sequencer and raw access
// Assumes: Software uses the plain register port, one clock
// Notes:   A new order while busy is ignored
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "tfh_cfg.svh"
module tfh_host
	import tfh_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	// Software port
	input  wire tfh_byte_t addr_i,
	input  wire tfh_byte_t wdata_i,
	input  wire logic      wr_i,
	input  wire logic      rd_i,
	output tfh_byte_t      rdata_o,
	output logic           irq_o,
	// Link
	tfh_link_if.host       link
);
	// ****************************************
	// State
	// ****************************************
	tfh_state_t             st_q, st_d;     // Sequencer
	tfh_byte_t              want_q;         // Wanted app code
	tfh_byte_t              ad_q;           // Raw access offset
	tfh_byte_t              wd_q;           // Raw access data
	tfh_byte_t              got_q;          // Raw read result
	tfh_byte_t              la_q, la_d;     // Link offset
	tfh_byte_t              lw_q, lw_d;     // Link write data
	logic                   lwr_q, lwr_d;   // Link write strobe
	logic                   lrd_q, lrd_d;   // Link read strobe
	logic                   rd_prev_q;      // Link read answer stands now
	logic [`TFH_H_NIRQ-1:0] mask_q;         // Interrupt mask
	logic [`TFH_H_NIRQ-1:0] ev_st;          // Sticky events
	logic [`TFH_H_NIRQ-1:0] ev_set;         // Event pulses
	logic                   irq_q;          // Interrupt output
	tfh_byte_t              rdata_q;        // Read data
	tfh_byte_t              rd_mux;         // Read selection

	// ****************************************
	// Decode
	// ****************************************
	wire idle     = st_q == TFH_ST_IDLE;
	wire wr_sw    = wr_i && addr_i == `TFH_H_SWITCH;
	wire wr_go    = wr_i && addr_i == `TFH_H_GO;
	wire go_wr    = wr_go && wdata_i[`TFH_H_GO_WR];
	wire go_rd    = wr_go && wdata_i[`TFH_H_GO_RD] && !wdata_i[`TFH_H_GO_WR];
	wire wr_irq   = wr_i && addr_i == `TFH_H_IRQ_ST;
	wire matched  = st_q == TFH_ST_CHK && rd_prev_q && link.rdata == want_q;
	wire [`TFH_H_NIRQ-1:0] ev_clr = wr_irq ? wdata_i[`TFH_H_NIRQ-1:0] : `TFH_H_IRQ_RST;
	assign ev_set[`TFH_H_EV_SWITCH] = matched;
	assign ev_set[`TFH_H_EV_DEVINT] = !link.int_n;
	assign ev_set[`TFH_H_EV_ACCESS] = st_q == TFH_ST_ACC && !lwr_q && !lrd_q;

	// ****************************************
	// Sequencer
	// ****************************************
	// Next state and link strobes
	always_comb begin
		st_d  = st_q;
		la_d  = la_q;
		lw_d  = lw_q;
		lwr_d = 1'b0;
		lrd_d = 1'b0;
		case (st_q)
			TFH_ST_IDLE: begin
				if (wr_sw) begin
					st_d = TFH_ST_REQ;
				end else if (go_wr) begin
					la_d  = ad_q;
					lw_d  = wd_q;
					lwr_d = 1'b1;
					st_d  = TFH_ST_ACC;
				end else if (go_rd) begin
					la_d  = ad_q;
					lrd_d = 1'b1;
					st_d  = TFH_ST_ACC;
				end
			end
			TFH_ST_REQ: begin
				la_d  = `TFH_OFF_REQ;
				lw_d  = want_q;
				lwr_d = 1'b1;
				st_d  = TFH_ST_POLL;
			end
			TFH_ST_POLL: begin
				la_d  = `TFH_OFF_APP;
				lrd_d = 1'b1;
				st_d  = TFH_ST_CHK;
			end
			TFH_ST_CHK: begin
				// Answer stands the cycle after the strobe
				if (rd_prev_q) begin
					st_d = matched ? TFH_ST_IDLE : TFH_ST_POLL;
				end
			end
			TFH_ST_ACC: begin
				// Hold until the strobe has been answered
				if (!lwr_q && !lrd_q) begin
					st_d = TFH_ST_IDLE;
				end
			end
			default: begin
				st_d = TFH_ST_IDLE;
			end
		endcase
	end

	// Sequencer and link flops
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q  <= TFH_ST_IDLE;
			la_q  <= `TFH_BYTE_RST;
			lw_q  <= `TFH_BYTE_RST;
			lwr_q <= 1'b0;
			lrd_q <= 1'b0;
			rd_prev_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			la_q  <= la_d;
			lw_q  <= lw_d;
			lwr_q <= lwr_d;
			lrd_q <= lrd_d;
			rd_prev_q <= lrd_q;
		end
	end

	// Orders from software
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			want_q <= `TFH_BYTE_RST;
			ad_q   <= `TFH_BYTE_RST;
			wd_q   <= `TFH_BYTE_RST;
			mask_q <= `TFH_H_IRQ_RST;
		end else begin
			if (wr_sw && idle) begin
				want_q <= wdata_i;
			end
			if (wr_i && addr_i == `TFH_H_ADDR) begin
				ad_q <= wdata_i;
			end
			if (wr_i && addr_i == `TFH_H_WDATA) begin
				wd_q <= wdata_i;
			end
			if (wr_i && addr_i == `TFH_H_IRQ_MASK) begin
				mask_q <= wdata_i[`TFH_H_NIRQ-1:0];
			end
		end
	end

	// Raw read capture
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			got_q <= `TFH_BYTE_RST;
		end else if (st_q == TFH_ST_ACC && rd_prev_q) begin
			got_q <= link.rdata;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	tfh_sticky #(
		.W(`TFH_H_NIRQ)
	) u_ev (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.set_i  (ev_set),
		.clr_i  (ev_clr),
		.q_o    (ev_st)
	);

	// ****************************************
	// Software read path
	// ****************************************
	// Read selection
	always_comb begin
		rd_mux = `TFH_BYTE_RST;
		if (addr_i == `TFH_H_SWITCH) begin
			rd_mux = want_q;
		end else if (addr_i == `TFH_H_STAT) begin
			rd_mux[0] = !idle;
		end else if (addr_i == `TFH_H_ADDR) begin
			rd_mux = ad_q;
		end else if (addr_i == `TFH_H_WDATA) begin
			rd_mux = wd_q;
		end else if (addr_i == `TFH_H_RDATA) begin
			rd_mux = got_q;
		end else if (addr_i == `TFH_H_IRQ_ST) begin
			rd_mux[`TFH_H_NIRQ-1:0] = ev_st;
		end else if (addr_i == `TFH_H_IRQ_MASK) begin
			rd_mux[`TFH_H_NIRQ-1:0] = mask_q;
		end
	end

	// Read data and interrupt flops
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= `TFH_BYTE_RST;
			irq_q   <= 1'b0;
		end else begin
			rdata_q <= rd_i ? rd_mux : `TFH_BYTE_RST;
			irq_q   <= |(ev_st & mask_q);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rdata_o    = rdata_q;
	assign irq_o      = irq_q;
	assign link.addr  = la_q;
	assign link.wdata = lw_q;
	assign link.wr    = lwr_q;
	assign link.rd    = lrd_q;
endmodule : tfh_host

// File: verification/tfh_link_properties.sv
// Purpose: Link properties for the sensor control registers
// Assumes: Both ends share clk_i and rst_n_i
// Notes:   Helper flops mirror what the host wrote on the link and what its reads answered
`timescale 1ns/1ps
`include "tfh_cfg.svh"
module tfh_link_properties
	import tfh_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	// Link signals
	input  wire tfh_byte_t addr,
	input  wire tfh_byte_t wdata,
	input  wire logic      wr,
	input  wire logic      rd,
	input  wire tfh_byte_t rdata,
	input  wire logic      int_n
);
	// ****************************************
	// Helper state
	// ****************************************
	logic [1:0] en_q;                                      // Enables as written
	logic [1:0] floor_q;                                   // Flags known set
	logic       pon_q;                                     // Oscillator bit
	logic       down_q;                                    // Low space closed
	logic       rd_e0_q;                                   // Control read answer
	logic       rd_e1_q;                                   // Flag read answer
	wire        wr_pwr = wr && addr == `TFH_OFF_PWR;
	wire        wr_flg = wr && addr == `TFH_OFF_FLAG;
	wire [1:0]  clr_w  = wr_flg ? wdata[1:0] : 2'h0;

	// Mirror host writes and answered reads
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			en_q    <= 2'h0;
			floor_q <= 2'h0;
			pon_q   <= 1'b1;
			down_q  <= 1'b1;
			rd_e0_q <= 1'b0;
			rd_e1_q <= 1'b0;
		end else begin
			rd_e0_q <= rd && addr == `TFH_OFF_PWR;
			rd_e1_q <= rd && addr == `TFH_OFF_FLAG;
			// Write one clears, read answer refreshes
			floor_q <= (rd_e1_q ? rdata[1:0] : floor_q) & ~clr_w;
			if (wr && addr == `TFH_OFF_INTEN) en_q <= wdata[1:0];
			if (wr_pwr) pon_q <= wdata[0];
			// Closed by a reset-bit write, open once core-up is seen
			if (wr_pwr && wdata[7]) down_q <= 1'b1;
			else if (rd_e0_q && rdata[6]) down_q <= 1'b0;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence flag_read_s;
		rd && addr == `TFH_OFF_FLAG;
	endsequence
	sequence ctrl_read_s;
		rd && addr == `TFH_OFF_PWR;
	endsequence

	idle_rdata_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not idle");
	flag_pad_a: assert property (flag_read_s |=> rdata[7:2] == 6'h00)
		else $error("flag spare bits not zero");
	ctrl_pad_a: assert property (ctrl_read_s |=> rdata[5:1] == 5'h00)
		else $error("control spare bits not zero");
	self_clear_a: assert property (ctrl_read_s and !$past(wr) and !$past(wr, 2) |=> !rdata[7])
		else $error("reset bit still set");
	closed_space_a: assert property (rd && addr < `TFH_HI_BASE && down_q && !$past(wr) |=> rdata == 8'h00)
		else $error("closed space answered");
	flag_keep_a: assert property (flag_read_s |=> (rdata[1:0] & $past(floor_q)) == $past(floor_q))
		else $error("flag lost without clear");
	int_level_a: assert property (flag_read_s |=> int_n == ((rdata[1:0] & $past(en_q)) == 2'h0))
		else $error("interrupt level wrong");
	enable_back_a: assert property (rd && addr == `TFH_OFF_INTEN |=> rdata[1:0] == $past(en_q))
		else $error("enable readback wrong");
	pon_back_a: assert property (ctrl_read_s |=> rdata[0] == $past(pon_q))
		else $error("oscillator bit wrong");
endmodule : tfh_link_properties

// File: verification/tof_host_control_registers_bench.sv
// Purpose: Bench for host controller and device joined by the link
// Assumes: One 10 MHz clock, bench plays firmware and software
// Notes:   Read results are queued and compared by a monitor
`timescale 1ns/1ps
`include "tfh_cfg.svh"
module tof_host_control_registers_bench;
	import tfh_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic       clk_i   = 1'b0;
	logic       rst_n_i = 1'b0;                            // Reset, active low
	tfh_byte_t  addr_i  = 8'h00;
	tfh_byte_t  wdata_i = 8'h00;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic       note_v  = 1'b0;                            // Result to compare
	tfh_byte_t  fw_app_code_i = 8'h00;
	logic       fw_app_code_we_i = 1'b0;
	tfh_byte_t  fw_rev_i = 8'h00;
	logic       fw_rev_we_i = 1'b0;
	logic [3:0] fw_p = 4'h0;                               // Up, standby, events
	tfh_byte_t  rdata_o, launch_request_o, v;
	logic       irq_o, cpu_reset_o, osc_wake_irq_o, standby_irq_o, osc_run_o, fw_idle_o;
	int         bad_count = 0, n_tests = 0, seed = 32'hdfba, r;
	int         cnt_rst = 0, cnt_wake = 0, cnt_sby = 0;
	bit         pend = 1'b0;
	tfh_byte_t  exp_q[$];
	string      name_q[$];
	tfh_byte_t  codes[2] = '{`TFH_CODE_MEAS, `TFH_CODE_BOOT};

	tfh_link_if link_if();
	tfh_host tfh_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(link_if.host));
	tfh_dev tfh_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if.dev),
		.fw_app_code_i(fw_app_code_i), .fw_app_code_we_i(fw_app_code_we_i),
		.fw_rev_i(fw_rev_i), .fw_rev_we_i(fw_rev_we_i), .fw_core_up_i(fw_p[3]),
		.fw_standby_i(fw_p[2]), .fw_hist_evt_i(fw_p[1]), .fw_result_evt_i(fw_p[0]),
		.launch_request_o(launch_request_o), .cpu_reset_o(cpu_reset_o),
		.osc_wake_irq_o(osc_wake_irq_o), .standby_irq_o(standby_irq_o),
		.osc_run_o(osc_run_o), .fw_idle_o(fw_idle_o));
	tfh_link_properties tfh_link_properties_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.addr(link_if.addr), .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd),
		.rdata(link_if.rdata), .int_n(link_if.int_n));

	// Clock
	initial forever #50 clk_i = ~clk_i;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input tfh_byte_t seen, input tfh_byte_t exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// Software write, one strobe cycle
	task automatic sw_wr(input tfh_byte_t a, input tfh_byte_t d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : sw_wr

	// Software read, chk marks it for the monitor, value always returned
	task automatic sw_rd(input tfh_byte_t a, input bit chk, output tfh_byte_t q);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		note_v <= chk;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		note_v <= 1'b0;
		@(negedge clk_i);
		q = rdata_o;
	endtask : sw_rd

	task automatic sw_chk(input tfh_byte_t a, input tfh_byte_t e, input string n);
		exp_q.push_back(e);
		name_q.push_back(n);
		sw_rd(a, 1'b1, v);
	endtask : sw_chk

	// Raw device access through the host, fixed settle
	task automatic dev_acc(input tfh_byte_t go, input tfh_byte_t a, input tfh_byte_t d);
		sw_wr(`TFH_H_ADDR, a);
		sw_wr(`TFH_H_WDATA, d);
		sw_wr(`TFH_H_GO, go);
		repeat (5) @(posedge clk_i);
	endtask : dev_acc

	task automatic dev_chk(input tfh_byte_t a, input tfh_byte_t e, input string n);
		dev_acc(8'h02, a, 8'h00);
		sw_chk(`TFH_H_RDATA, e, n);
	endtask : dev_chk

	// Firmware pulses: core up, standby done, histogram, result
	task automatic fw_set(input logic [3:0] p);
		@(posedge clk_i);
		fw_p <= p;
		@(posedge clk_i);
		fw_p <= 4'h0;
	endtask : fw_set

	// Host switch order, firmware answers late
	task automatic switch_app(input tfh_byte_t code);
		int k;
		sw_wr(`TFH_H_IRQ_ST, 8'h07);
		sw_wr(`TFH_H_SWITCH, code);
		for (k = 0; k < 40 && launch_request_o !== code; k++) @(posedge clk_i);
		check(launch_request_o, code, "launch request");
		repeat ((r & 7) + 2) @(posedge clk_i);
		sw_rd(`TFH_H_IRQ_ST, 1'b0, v);
		check(v & 8'h01, 8'h00, "early switch done");
		@(posedge clk_i);
		fw_app_code_i    <= code;
		fw_app_code_we_i <= 1'b1;
		@(posedge clk_i);
		fw_app_code_we_i <= 1'b0;
		for (k = 0; k < 40 && v[0] !== 1'b1; k++) sw_rd(`TFH_H_IRQ_ST, 1'b0, v);
		check({7'h0, irq_o}, 8'h01, "switch irq");
		dev_chk(`TFH_OFF_APP, code, "running code");
	endtask : switch_app

	// ****************************************
	// Monitor and pulse counters
	// ****************************************
	always @(posedge clk_i) begin
		if (pend) check(rdata_o, exp_q.pop_front(), name_q.pop_front());
		pend = rd_i && note_v;
		cnt_rst  += (cpu_reset_o === 1'b1);
		cnt_wake += (osc_wake_irq_o === 1'b1);
		cnt_sby  += (standby_irq_o === 1'b1);
	end

	// Watchdog
	initial begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		finish_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		r = $random(seed);
		dev_chk(`TFH_OFF_PWR, 8'h01, "control at reset");
		dev_acc(8'h01, `TFH_OFF_REQ, `TFH_CODE_MEAS);
		dev_chk(`TFH_OFF_REQ, 8'h00, "closed request");
		@(posedge clk_i);
		fw_rev_i    <= 8'h3A;
		fw_rev_we_i <= 1'b1;
		fw_set(4'h8);
		fw_rev_we_i <= 1'b0;
		dev_chk(`TFH_OFF_PWR, 8'h41, "core up");
		dev_chk(`TFH_OFF_REV, 8'h3A, "revision");
		sw_wr(`TFH_H_IRQ_MASK, 8'h01);
		foreach (codes[i]) switch_app(codes[i]);
		// Core reset, oscillator bit kept on
		dev_acc(8'h01, `TFH_OFF_PWR, 8'h81);
		check(tfh_byte_t'(cnt_rst), 8'h01, "core reset pulse");
		check(tfh_byte_t'(cnt_wake), 8'h00, "no wake while on");
		dev_chk(`TFH_OFF_PWR, 8'h01, "after core reset");
		fw_set(4'h8);
		dev_chk(`TFH_OFF_PWR, 8'h41, "core up again");
		dev_chk(`TFH_OFF_APP, 8'h00, "code after reset");
		// Standby and wake under each firmware image
		foreach (codes[i]) begin
			@(posedge clk_i);
			fw_app_code_i    <= codes[i];
			fw_app_code_we_i <= 1'b1;
			@(posedge clk_i);
			fw_app_code_we_i <= 1'b0;
			dev_acc(8'h01, `TFH_OFF_PWR, 8'h00);
			check(tfh_byte_t'(cnt_sby), tfh_byte_t'(i + 1), "standby irq");
			fw_set(4'h4);
			@(negedge clk_i);
			check({7'h0, osc_run_o}, 8'h00, "oscillator stopped");
			dev_chk(`TFH_OFF_PWR, 8'h40, "oscillator bit off");
			dev_acc(8'h01, `TFH_OFF_PWR, 8'h01);
			check(tfh_byte_t'(cnt_wake), tfh_byte_t'(i + 1), "wake irq");
			check({7'h0, osc_run_o}, 8'h01, "oscillator running");
			check({7'h0, fw_idle_o}, {7'h0, codes[i] == `TFH_CODE_MEAS}, "idle");
			check(tfh_byte_t'(cnt_rst), tfh_byte_t'(1 + i), "boot reset");
		end
		// Random events against random enables
		repeat (6) begin
			r = $random(seed);
			dev_acc(8'h01, `TFH_OFF_INTEN, {6'h0, r[1:0]});
			fw_set({2'h0, r[3:2]});
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			check({7'h0, link_if.int_n}, {7'h0, (r[3:2] & r[1:0]) == 2'h0}, "int level");
			dev_acc(8'h01, `TFH_OFF_FLAG, 8'h00);
			dev_chk(`TFH_OFF_FLAG, {6'h0, r[3:2]}, "flags kept");
			dev_chk(`TFH_OFF_INTEN, {6'h0, r[1:0]}, "enables");
			dev_acc(8'h01, `TFH_OFF_FLAG, 8'hFF);
			dev_chk(`TFH_OFF_FLAG, 8'h00, "flags cleared");
		end
		finish_test();
	end
endmodule : tof_host_control_registers_bench
